// File: mct_pkg.sv
// constants shared by the main clock controller and time base
// assumes a single 250 MHz oscillator clock and a 32-bit AXI4-Lite register bus
package mct_pkg;
    // register byte addresses
    localparam logic [3:0] ADDR_CTRL_STATUS = 4'h0;
    localparam logic [3:0] ADDR_EVENT_STATUS = 4'h4;
    localparam logic [3:0] ADDR_EVENT_MASK = 4'h8;
    localparam logic [3:0] ADDR_POWER_STATE = 4'hC;
    // clock_ctrl_status field positions
    localparam int BIT_CLOCK_OUT_SELECT = 7;
    localparam int BIT_PRESCALE_HI = 6;
    localparam int BIT_PRESCALE_LO = 5;
    localparam int BIT_SLOW_SELECT = 4;
    localparam int BIT_TIMEBASE_HI = 3;
    localparam int BIT_TIMEBASE_LO = 2;
    localparam int BIT_OVERFLOW_IRQ_ENABLE = 1;
    localparam int BIT_OVERFLOW_FLAG = 0;
    localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hFE;
    // event status / mask layout
    localparam int EVENT_BITS = 2;
    localparam int EV_OVERFLOW = 0;
    localparam int EV_WAKEUP = 1;
    localparam logic [1:0] EVENT_MASK_RESET = 2'h0;
    // time base lengths in oscillator cycles
    localparam int unsigned TB_PERIOD_00 = 16000;
    localparam int unsigned TB_PERIOD_01 = 32000;
    localparam int unsigned TB_PERIOD_10 = 80000;
    localparam int unsigned TB_PERIOD_11 = 200000;
    localparam int TB_COUNT_W = 18;
    // shared interrupt vector
    localparam logic [15:0] TB_VECTOR_ADDR = 16'hFFF8;
    localparam logic [3:0] PRESCALE_CNT_RESET = 4'h0;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PM_RUN = 2'b00,
        PM_WAIT = 2'b01,
        PM_ACTIVE_HALT = 2'b10,
        PM_HALT = 2'b11
    } mct_power_t;
endpackage

// File: mct_prescale.sv
// cpu clock enable generator: one pulse per cpu clock period
// assumes the oscillator clock is the module clock
`timescale 1ns/1ps
module mct_prescale (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic run,
    input wire logic slow,
    input wire logic [1:0] sel,
    output logic tick
);
    logic [3:0] cnt;
    logic [3:0] limit;

    // divisor minus one: 1, 3, 7, 15
    assign limit = {sel == 2'h3, sel[1], sel != 2'h0, 1'b1};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= mct_pkg::PRESCALE_CNT_RESET;
            tick <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                cnt <= mct_pkg::PRESCALE_CNT_RESET;
                tick <= 1'b0;
            end else if (!slow) begin
                cnt <= mct_pkg::PRESCALE_CNT_RESET;
                tick <= 1'b1;
            end else if (cnt >= limit) begin
                cnt <= mct_pkg::PRESCALE_CNT_RESET;
                tick <= 1'b1;
            end else begin
                cnt <= cnt + 4'h1;
                tick <= 1'b0;
            end
        end
    end
endmodule // mct_prescale

// File: mct_top.sv
// main clock controller with time base, power mode sequencing and axi4-lite registers
// assumes the cpu core reports wait/halt entry and wake-capable interrupts as pulses
`timescale 1ns/1ps
module mct_top #(
    parameter int unsigned PERIOD_00 = mct_pkg::TB_PERIOD_00,
    parameter int unsigned PERIOD_01 = mct_pkg::TB_PERIOD_01,
    parameter int unsigned PERIOD_10 = mct_pkg::TB_PERIOD_10,
    parameter int unsigned PERIOD_11 = mct_pkg::TB_PERIOD_11
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic WAIT_ENTER,
    input wire logic HALT_ENTER,
    input wire logic HALT_WAKE,
    input wire logic CPU_IRQ_MASKED,
    output logic CPU_CLK_EN,
    output logic CLOCK_OUT_EN,
    output logic CLOCK_OUT_OE_N,
    output logic TB_IRQ_REQ,
    output logic [15:0] TB_IRQ_VECTOR,
    output logic [1:0] POWER_MODE,
    output logic IRQ
);
    // control register fields
    logic clock_out_select;
    logic [1:0] cpu_prescale_sel;
    logic slow_select;
    logic [1:0] timebase_sel;
    logic overflow_irq_enable;
    logic overflow_flag;
    logic [mct_pkg::EVENT_BITS-1:0] event_status;
    logic [mct_pkg::EVENT_BITS-1:0] event_mask;

    mct_pkg::mct_power_t power_state;
    mct_pkg::mct_power_t next_power_state;

    // time base
    logic [1:0] active_tb_sel;
    logic [mct_pkg::TB_COUNT_W-1:0] tb_count;
    logic [mct_pkg::TB_COUNT_W-1:0] tb_last;
    logic tb_running;
    logic tb_overflow;
    logic tb_wake;
    logic wake_event;

    // bus
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic wr_fire;
    logic wr_hit;
    logic regs_frozen;
    logic rd_fire;
    logic [3:0] ar_addr;
    logic [31:0] rd_value;
    logic rd_hit;
    logic rd_ctrl;
    logic rd_event;
    logic cpu_tick;
    // unaligned code that matches no register: marks addresses beyond the map
    localparam logic [3:0] ADDR_OUTSIDE = 4'h1;

    // ---------------- time base counter ----------------
    always_comb begin
        case (active_tb_sel)
            2'h0: tb_last = mct_pkg::TB_COUNT_W'(PERIOD_00 - 1);
            2'h1: tb_last = mct_pkg::TB_COUNT_W'(PERIOD_01 - 1);
            2'h2: tb_last = mct_pkg::TB_COUNT_W'(PERIOD_10 - 1);
            default: tb_last = mct_pkg::TB_COUNT_W'(PERIOD_11 - 1);
        endcase
    end

    assign tb_running = (power_state != mct_pkg::PM_HALT);
    assign tb_overflow = tb_running && (tb_count == tb_last);

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            tb_count <= '0;
            active_tb_sel <= 2'h0;
        end else if (CE && tb_running) begin
            if (tb_overflow) begin
                tb_count <= '0;
                active_tb_sel <= timebase_sel;
            end else begin
                tb_count <= tb_count + 1'b1;
            end
        end
    end

    // ---------------- power mode sequencing ----------------
    // time base interrupt used as wake source: needs the enable, not the cpu mask
    assign tb_wake = tb_overflow && overflow_irq_enable;

    always_comb begin
        next_power_state = power_state;
        case (power_state)
            mct_pkg::PM_RUN: begin
                if (HALT_ENTER) begin
                    if (overflow_irq_enable) begin
                        next_power_state = mct_pkg::PM_ACTIVE_HALT;
                    end else begin
                        next_power_state = mct_pkg::PM_HALT;
                    end
                end else if (WAIT_ENTER) begin
                    next_power_state = mct_pkg::PM_WAIT;
                end
            end
            mct_pkg::PM_WAIT: begin
                if (tb_wake || HALT_WAKE) begin
                    next_power_state = mct_pkg::PM_RUN;
                end
            end
            mct_pkg::PM_ACTIVE_HALT: begin
                if (tb_wake || HALT_WAKE) begin
                    next_power_state = mct_pkg::PM_RUN;
                end
            end
            mct_pkg::PM_HALT: begin
                if (HALT_WAKE) begin
                    next_power_state = mct_pkg::PM_RUN;
                end
            end
            default: next_power_state = mct_pkg::PM_RUN;
        endcase
    end

    assign wake_event = (power_state != mct_pkg::PM_RUN) && (next_power_state == mct_pkg::PM_RUN);

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            power_state <= mct_pkg::PM_RUN;
        end else if (CE) begin
            power_state <= next_power_state;
        end
    end

    assign regs_frozen = (power_state == mct_pkg::PM_ACTIVE_HALT)
        || (power_state == mct_pkg::PM_HALT);

    // ---------------- axi4-lite write channel ----------------
    assign wr_fire = aw_held && w_held && !S_AXI_BVALID;
    assign wr_hit = (aw_addr == mct_pkg::ADDR_CTRL_STATUS) || (aw_addr == mct_pkg::ADDR_EVENT_MASK)
        || (aw_addr == mct_pkg::ADDR_EVENT_STATUS) || (aw_addr == mct_pkg::ADDR_POWER_STATE);

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
        end else if (CE) begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= (S_AXI_AWADDR[31:4] != 28'h0) ? ADDR_OUTSIDE
                    : {S_AXI_AWADDR[3:2], 2'b00};
                S_AXI_AWREADY <= 1'b0;
            end else begin
                if (wr_fire) begin
                    aw_held <= 1'b0;
                end
                S_AXI_AWREADY <= !aw_held || wr_fire ? !S_AXI_AWREADY || !aw_held : 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            w_held <= 1'b0;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
            S_AXI_WREADY <= 1'b0;
        end else if (CE) begin
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA[7:0];
                w_lane0 <= S_AXI_WSTRB[0];
                S_AXI_WREADY <= 1'b0;
            end else begin
                if (wr_fire) begin
                    w_held <= 1'b0;
                end
                S_AXI_WREADY <= !w_held || wr_fire ? !S_AXI_WREADY || !w_held : 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= mct_pkg::RESP_OKAY;
        end else if (CE) begin
            if (wr_fire) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_hit ? mct_pkg::RESP_OKAY : mct_pkg::RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // ---------------- control register ----------------
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            clock_out_select <= mct_pkg::CTRL_STATUS_RESET[mct_pkg::BIT_CLOCK_OUT_SELECT];
            cpu_prescale_sel <= mct_pkg::CTRL_STATUS_RESET[mct_pkg::BIT_PRESCALE_HI:
                mct_pkg::BIT_PRESCALE_LO];
            slow_select <= mct_pkg::CTRL_STATUS_RESET[mct_pkg::BIT_SLOW_SELECT];
            timebase_sel <= mct_pkg::CTRL_STATUS_RESET[mct_pkg::BIT_TIMEBASE_HI:
                mct_pkg::BIT_TIMEBASE_LO];
            overflow_irq_enable <= mct_pkg::CTRL_STATUS_RESET[mct_pkg::BIT_OVERFLOW_IRQ_ENABLE];
        end else if (CE && wr_fire && w_lane0 && !regs_frozen
                && aw_addr == mct_pkg::ADDR_CTRL_STATUS) begin
            clock_out_select <= w_data[mct_pkg::BIT_CLOCK_OUT_SELECT];
            cpu_prescale_sel <= w_data[mct_pkg::BIT_PRESCALE_HI:mct_pkg::BIT_PRESCALE_LO];
            slow_select <= w_data[mct_pkg::BIT_SLOW_SELECT];
            timebase_sel <= w_data[mct_pkg::BIT_TIMEBASE_HI:mct_pkg::BIT_TIMEBASE_LO];
            overflow_irq_enable <= w_data[mct_pkg::BIT_OVERFLOW_IRQ_ENABLE];
        end
    end

    // overflow flag: set wins over the read clear
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            overflow_flag <= mct_pkg::CTRL_STATUS_RESET[mct_pkg::BIT_OVERFLOW_FLAG];
        end else if (CE) begin
            if (tb_overflow) begin
                overflow_flag <= 1'b1;
            end else if (rd_fire && rd_ctrl) begin
                overflow_flag <= 1'b0;
            end
        end
    end

    // ---------------- event status and mask ----------------
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            event_status <= '0;
        end else if (CE) begin
            for (int i = 0; i < mct_pkg::EVENT_BITS; i++) begin
                if ((i == mct_pkg::EV_OVERFLOW && tb_overflow)
                        || (i == mct_pkg::EV_WAKEUP && wake_event)) begin
                    event_status[i] <= 1'b1;
                end else if (rd_fire && rd_event) begin
                    event_status[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            event_mask <= mct_pkg::EVENT_MASK_RESET;
        end else if (CE && wr_fire && w_lane0 && aw_addr == mct_pkg::ADDR_EVENT_MASK) begin
            event_mask <= w_data[mct_pkg::EVENT_BITS-1:0];
        end
    end

    // ---------------- axi4-lite read channel ----------------
    assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
    assign ar_addr = (S_AXI_ARADDR[31:4] != 28'h0) ? ADDR_OUTSIDE : {S_AXI_ARADDR[3:2], 2'b00};
    assign rd_ctrl = (ar_addr == mct_pkg::ADDR_CTRL_STATUS);
    assign rd_event = (ar_addr == mct_pkg::ADDR_EVENT_STATUS);

    always_comb begin
        rd_value = 32'h0000_0000;
        rd_hit = 1'b1;
        case (ar_addr)
            mct_pkg::ADDR_CTRL_STATUS: rd_value[7:0] = {clock_out_select, cpu_prescale_sel,
                slow_select, timebase_sel, overflow_irq_enable, overflow_flag};
            mct_pkg::ADDR_EVENT_STATUS: rd_value[mct_pkg::EVENT_BITS-1:0] = event_status;
            mct_pkg::ADDR_EVENT_MASK: rd_value[mct_pkg::EVENT_BITS-1:0] = event_mask;
            mct_pkg::ADDR_POWER_STATE: rd_value[1:0] = power_state;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= mct_pkg::RESP_OKAY;
        end else if (CE) begin
            if (rd_fire) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_value;
                S_AXI_RRESP <= rd_hit ? mct_pkg::RESP_OKAY : mct_pkg::RESP_SLVERR;
            end else if (S_AXI_RVALID) begin
                if (S_AXI_RREADY) begin
                    S_AXI_RVALID <= 1'b0;
                end
            end else begin
                S_AXI_ARREADY <= 1'b1;
            end
        end
    end

    // ---------------- clocks out ----------------
    mct_prescale u_prescale (
        .clk(CLOCK),
        .rst_n(RST_N),
        .ce(CE),
        .run(!regs_frozen),
        .slow(slow_select),
        .sel(cpu_prescale_sel),
        .tick(cpu_tick)
    );

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            CPU_CLK_EN <= 1'b0;
            CLOCK_OUT_EN <= 1'b0;
            CLOCK_OUT_OE_N <= 1'b1;
            TB_IRQ_REQ <= 1'b0;
            TB_IRQ_VECTOR <= mct_pkg::TB_VECTOR_ADDR;
            POWER_MODE <= mct_pkg::PM_RUN;
            IRQ <= 1'b0;
        end else if (CE) begin
            CPU_CLK_EN <= cpu_tick;
            // pad mux gates the oscillator clock onto the pin while enabled
            CLOCK_OUT_EN <= clock_out_select && !regs_frozen;
            CLOCK_OUT_OE_N <= !(clock_out_select && !regs_frozen);
            TB_IRQ_REQ <= overflow_flag && overflow_irq_enable && !CPU_IRQ_MASKED;
            TB_IRQ_VECTOR <= mct_pkg::TB_VECTOR_ADDR;
            POWER_MODE <= next_power_state;
            IRQ <= |(event_status & event_mask);
        end
    end
endmodule // mct_top

// File: mct_props.sv
// port-level checker for the clock controller with time base
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module mct_props (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic HALT_ENTER,
    input wire logic HALT_WAKE,
    input wire logic CPU_IRQ_MASKED,
    input wire logic CPU_CLK_EN,
    input wire logic CLOCK_OUT_EN,
    input wire logic CLOCK_OUT_OE_N,
    input wire logic TB_IRQ_REQ,
    input wire logic [15:0] TB_IRQ_VECTOR,
    input wire logic [1:0] POWER_MODE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    a_pin_drive: assert property (CLOCK_OUT_OE_N == !CLOCK_OUT_EN)
        else $error("pin enable does not follow clock-out enable");
    a_clkout_halted: assert property (POWER_MODE[1] [*2] |-> !CLOCK_OUT_EN)
        else $error("clock-out active while halted");
    a_mask_blocks: assert property ($past(CPU_IRQ_MASKED) |-> !TB_IRQ_REQ)
        else $error("interrupt request while cpu mask active");
    a_wait_wake: assert property (POWER_MODE == 2'h1 && HALT_WAKE |=> POWER_MODE == 2'h0)
        else $error("wake did not end wait");
    a_halt_stays: assert property (POWER_MODE == 2'h3 && !HALT_WAKE |=> POWER_MODE == 2'h3)
        else $error("halt left without wake");
    a_cpu_stopped: assert property (POWER_MODE[1] [*3] |-> !CPU_CLK_EN)
        else $error("cpu clock runs while halted");
    a_halt_entry: assert property (POWER_MODE == 2'h0 && HALT_ENTER |=> POWER_MODE[1])
        else $error("halt instruction did not halt");
    a_vector_fixed: assert property (TB_IRQ_VECTOR == 16'hFFF8)
        else $error("wrong interrupt vector");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read not answered next cycle");
    a_write_done: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("write response not released");
    c_active_halt: cover property (POWER_MODE == 2'h2);
    c_full_halt: cover property (POWER_MODE == 2'h3);
    c_wait: cover property (POWER_MODE == 2'h1);
    c_irq_req: cover property ($rose(TB_IRQ_REQ));
endmodule // mct_props

bind mct_top mct_props u_props (.CLOCK(CLOCK), .RST_N(RST_N), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .HALT_ENTER(HALT_ENTER), .HALT_WAKE(HALT_WAKE),
    .CPU_IRQ_MASKED(CPU_IRQ_MASKED), .CPU_CLK_EN(CPU_CLK_EN), .CLOCK_OUT_EN(CLOCK_OUT_EN),
    .CLOCK_OUT_OE_N(CLOCK_OUT_OE_N), .TB_IRQ_REQ(TB_IRQ_REQ), .TB_IRQ_VECTOR(TB_IRQ_VECTOR),
    .POWER_MODE(POWER_MODE));

// File: mct_cpu_model.sv
// behavioural cpu core: turns bench requests into wait/halt/wake pulses and the irq mask
// assumes requests last one cycle on the shared oscillator clock
`timescale 1ns/1ps
module mct_cpu_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [1:0] op,
    input wire logic mask_req,
    output logic wait_enter,
    output logic halt_enter,
    output logic halt_wake,
    output logic irq_masked
);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_enter <= 1'h0;
            halt_enter <= 1'h0;
            halt_wake <= 1'h0;
            irq_masked <= 1'h0;
        end else begin
            wait_enter <= go && op == 2'h1;
            halt_enter <= go && op == 2'h2;
            halt_wake <= go && op == 2'h3;
            irq_masked <= mask_req;
        end
    end
endmodule // mct_cpu_model

// File: main_clock_ctrl_timebase_test.sv
// self-checking bench: register traffic, cpu clock rates, time base and power modes
// assumes the package and design are compiled first; periods are shortened
`timescale 1ns/1ps
module main_clock_ctrl_timebase_test;
    localparam int PER[4] = '{20, 40, 100, 250};
    localparam int ORD[4] = '{3, 1, 2, 0};
    logic clock = 1'h0;
    logic rst_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
    logic rready = 1'h0, go = 1'h0, mask_req = 1'h0;
    logic [1:0] op = 2'h0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, clk_en, co_en, co_oe_n, tb_req, irq;
    logic wait_enter, halt_enter, halt_wake, irq_masked;
    logic [1:0] bresp, rresp, pmode, resp;
    logic [31:0] rdata, rd;
    logic [15:0] vec;
    int num_errors = 0, compares = 0, cyc = 0, t0, t1, t2, n, p;

    initial forever #2 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    mct_top #(.PERIOD_00(PER[0]), .PERIOD_01(PER[1]), .PERIOD_10(PER[2]), .PERIOD_11(PER[3])) DUT (
        .CLOCK(clock), .RST_N(rst_n), .CE(1'h1), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .WAIT_ENTER(wait_enter), .HALT_ENTER(halt_enter), .HALT_WAKE(halt_wake),
        .CPU_IRQ_MASKED(irq_masked), .CPU_CLK_EN(clk_en), .CLOCK_OUT_EN(co_en),
        .CLOCK_OUT_OE_N(co_oe_n), .TB_IRQ_REQ(tb_req), .TB_IRQ_VECTOR(vec), .POWER_MODE(pmode),
        .IRQ(irq));

    mct_cpu_model cpu_core (.clk(clock), .rst_n(rst_n), .go(go), .op(op), .mask_req(mask_req),
        .wait_enter(wait_enter), .halt_enter(halt_enter), .halt_wake(halt_wake),
        .irq_masked(irq_masked));

    task automatic report_and_stop;
        $display("compares %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'h1;
        w = 1'h1;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (aw || w) begin
            @(posedge clock);
            if (aw && awready === 1'h1) begin
                aw = 1'h0;
                awvalid <= 1'h0;
            end
            if (w && wready === 1'h1) begin
                w = 1'h0;
                wvalid <= 1'h0;
            end
        end
        do @(posedge clock); while (bvalid !== 1'h1);
        resp = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd_reg(input logic [31:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clock); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge clock); while (rvalid !== 1'h1);
        rd = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask

    task automatic wait_irq(output int t);
        do @(posedge clock); while (irq !== 1'h1);
        t = cyc;
    endtask

    task automatic wait_mode(input logic [1:0] m);
        do @(posedge clock); while (pmode !== m);
    endtask

    // one core request, then time for the pulse to reach the power sequencer
    task automatic cpu(input logic [1:0] k);
        @(posedge clock);
        go <= 1'h1;
        op <= k;
        @(posedge clock);
        go <= 1'h0;
        repeat (3) @(posedge clock);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        report_and_stop;
    end

    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'h1;
        rd_reg(32'h0);
        chk(rd, 32'h0);
        rd_reg(32'h8);
        chk(rd, 32'h0);
        rd_reg(32'h20);
        chk(rd, 32'h0);
        chk(resp, 2'h2);
        wr(32'h20, 32'hFF);
        chk(resp, 2'h2);
        chk(vec, 16'hFFF8);
        // cpu clock enable rate: four slow divisors, then normal mode
        for (int k = 0; k < 5; k++) begin
            wr(32'h0, k < 4 ? 32'h10 | (k << 5) : 32'h0);
            repeat (20) @(posedge clock);
            n = 0;
            repeat (64) begin
                @(posedge clock);
                n += (clk_en === 1'h1);
            end
            chk(n, k < 4 ? 64 >> (k + 1) : 64);
        end
        // period lengths, deferred period change, flag set and read-clear
        wr(32'h8, 32'h1);
        rd_reg(32'h4);
        p = 0;
        for (int i = 0; i < 4; i++) begin
            wait_irq(t0);
            rd_reg(32'h4);
            wr(32'h0, ORD[i] << 2);
            wait_irq(t1);
            chk(t1 - t0, PER[p]);
            rd_reg(32'h0);
            chk(rd[7:0], (ORD[i] << 2) | 1);
            rd_reg(32'h0);
            chk(rd[0], 1'h0);
            rd_reg(32'h4);
            wait_irq(t2);
            chk(t2 - t1, PER[ORD[i]]);
            rd_reg(32'h4);
            p = ORD[i];
        end
        wr(32'h0, 32'h80);
        repeat (2) @(posedge clock);
        chk({co_en, co_oe_n}, 2'h2);
        wr(32'h0, 32'h8E);
        // clear stale events so the wait lands on a fresh long period
        rd_reg(32'h4);
        wait_irq(t0);
        rd_reg(32'h4);
        repeat (2) @(posedge clock);
        chk(tb_req, 1'h1);
        mask_req <= 1'h1;
        repeat (3) @(posedge clock);
        chk(tb_req, 1'h0);
        mask_req <= 1'h0;
        repeat (3) @(posedge clock);
        chk(tb_req, 1'h1);
        rd_reg(32'h0);
        repeat (2) @(posedge clock);
        chk(tb_req, 1'h0);
        cpu(2'h2);
        chk(pmode, 2'h2);
        // cpu enable trails the mode by two flops
        @(posedge clock);
        chk({co_en, clk_en}, 2'h0);
        wr(32'h0, 32'h0);
        wait_mode(2'h0);
        rd_reg(32'h0);
        chk(rd[7:1], 7'h47);
        rd_reg(32'h4);
        chk(rd[1:0], 2'h3);
        wr(32'h0, 32'h0C);
        rd_reg(32'h4);
        cpu(2'h2);
        chk(pmode, 2'h3);
        repeat (300) @(posedge clock);
        chk({irq, pmode}, 3'h3);
        cpu(2'h3);
        chk(pmode, 2'h0);
        cpu(2'h1);
        chk(pmode, 2'h1);
        cpu(2'h3);
        chk(pmode, 2'h0);
        wr(32'h0, 32'h0E);
        rd_reg(32'h4);
        cpu(2'h1);
        wait_mode(2'h0);
        rd_reg(32'h4);
        chk(rd[1:0], 2'h3);
        report_and_stop;
    end
endmodule // main_clock_ctrl_timebase_test
